/* File: include/tx_retry_pkg.sv */
// Purpose: Shared constants for the transmit retry and status controller
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: Status codes and retry limits are fixed by the link behaviour
`default_nettype none
package tx_retry_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXREQ = 8'h04;
  localparam logic [7:0] ADDR_TXSTAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RR_LSB = 8;
  localparam int TXREQ_ID_LSB = 0;
  localparam int TXREQ_BCAST_BIT = 8;
  localparam int TXSTAT_CODE_LSB = 8;
  localparam int TXSTAT_LINK_LSB = 16;
  localparam int TXSTAT_APP_LSB = 24;
  localparam int TXSTAT_BUSY_BIT = 31;
  localparam int IRQ_STATUS_BIT = 0;
  localparam int IRQ_DROP_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] RR_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // ==========================================================
  // Link behaviour
  localparam logic [1:0] LINK_ATTEMPTS = 2'h3;
  localparam logic [1:0] LINK_RETRIES_MAX = 2'h3;

  // Transmit status codes
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_NO_ACK = 8'h01;
  localparam logic [7:0] ST_CCA_FAIL = 8'h02;
  localparam logic [7:0] ST_NET_ACK_FAIL = 8'h21;

  // Controller states
  typedef enum logic [1:0] {
    S_IDLE,
    S_SEND,
    S_WAIT,
    S_DONE
  } tx_state_t;

endpackage : tx_retry_pkg

`default_nettype wire

/* File: rtl/tx_retry_ctrl.sv */
// Purpose: Transmit-side retry engine and status reporter for a radio node
// Assumes: Radio result pins are asynchronous; registers on classic Wishbone
// Notes: One request in flight; requests while busy are dropped and flagged
//   A busy channel uses three attempts per try, recorded as two link retries
//   Result pins are read only on a done toggle, so they must settle first
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tx_retry_ctrl
  import tx_retry_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Radio transmit request
  output logic radio_start,
  output logic radio_hdr_en,
  output logic radio_dup_detect,
  output logic radio_ack_req,
  output logic radio_broadcast,
  // Radio attempt result (asynchronous)
  input wire logic radio_done_tgl,
  input wire logic radio_cca_fail,
  input wire logic radio_ack_rcvd,
  input wire logic radio_net_ack,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Declarations
  tx_state_t state_q;
  logic [1:0] mac_mode_setting_q;
  logic [7:0] application_retry_count_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [7:0] frame_id_q;
  logic bcast_q;
  logic [1:0] link_try_q;
  logic [7:0] app_try_q;
  logic [7:0] code_q;
  logic [7:0] last_id_q;
  logic [7:0] last_code_q;
  logic [1:0] last_link_q;
  logic [7:0] last_app_q;
  logic [2:0] done_sync_q;
  logic [1:0] cca_sync_q;
  logic [1:0] ack_sync_q;
  logic [1:0] nack_sync_q;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic req_wr;
  logic done_evt;
  logic hdr_on;
  logic ack_on;
  logic app_on;
  logic app_left;
  logic status_evt;
  logic drop_evt;
  logic [31:0] rd_d;
  logic [7:0] ctrl_lo_d;
  logic [7:0] mask_lo_d;
  logic [IRQ_W-1:0] irq_set;

  // Byte-lane merge for register writes
  function automatic logic [7:0] lane(input logic [3:0] sel, input int idx, input logic [7:0] old_v,
                                      input logic [31:0] wdat);
    lane = sel[idx] ? wdat[idx*8 +: 8] : old_v;
  endfunction : lane

  // ==========================================================
  // Bus decode
  // Access taken on the first cycle of a request, acked the next
  // Writes commit on that first edge, a cycle before the master samples ack;
  // the ack term keeps a request still held in the ack cycle from repeating
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  assign req_wr = bus_wr & (wb_adr_i == ADDR_TXREQ) & wb_sel_i[0];

  // Low byte of the control and mask registers after the write, lanes merged
  assign ctrl_lo_d = lane(wb_sel_i, 0, {6'h00, mac_mode_setting_q}, wb_dat_i);
  assign mask_lo_d = lane(wb_sel_i, 0, {6'h00, irq_mask_q}, wb_dat_i);

  // Mode decode
  assign hdr_on = (mac_mode_setting_q == 2'h0) | (mac_mode_setting_q == 2'h3);
  assign ack_on = (mac_mode_setting_q == 2'h0) | (mac_mode_setting_q == 2'h2);
  // Count 0 with the header on behaves as no application retries
  assign app_on = hdr_on & (application_retry_count_q != 8'h00);
  assign app_left = app_on & (app_try_q < application_retry_count_q);

  // ==========================================================
  // Result pin synchronisers
  // Levels share the toggle's two stages, so each level is read in the
  // cycle its toggle edge shows; the third toggle stage finds that edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_sync_q <= 3'h0;
      cca_sync_q <= 2'h0;
      ack_sync_q <= 2'h0;
      nack_sync_q <= 2'h0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], radio_done_tgl};
      cca_sync_q <= {cca_sync_q[0], radio_cca_fail};
      ack_sync_q <= {ack_sync_q[0], radio_ack_rcvd};
      nack_sync_q <= {nack_sync_q[0], radio_net_ack};
    end
  end

  // Toggle edge after both stages
  assign done_evt = done_sync_q[2] ^ done_sync_q[1];

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_mode_setting_q <= MODE_RESET;
      application_retry_count_q <= RR_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (bus_wr) begin
      if (wb_adr_i == ADDR_CTRL) begin
        mac_mode_setting_q <= ctrl_lo_d[CTRL_MODE_LSB +: 2];
        application_retry_count_q <= lane(wb_sel_i, 1, application_retry_count_q, wb_dat_i);
      end
      if (wb_adr_i == ADDR_IRQ_MASK) begin
        irq_mask_q <= mask_lo_d[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Retry engine
  // A done toggle outside the wait state is ignored, so a late result
  // from a finished request cannot end the next one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      frame_id_q <= 8'h00;
      bcast_q <= 1'b0;
      link_try_q <= 2'h0;
      app_try_q <= 8'h00;
      code_q <= ST_SUCCESS;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (req_wr) begin
            frame_id_q <= wb_dat_i[TXREQ_ID_LSB +: 8];
            bcast_q <= wb_dat_i[TXREQ_BCAST_BIT];
            link_try_q <= 2'h0;
            app_try_q <= 8'h00;
            state_q <= S_SEND;
          end
        end
        S_SEND: begin
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (done_evt) begin
            if (cca_sync_q[1]) begin
              // Busy channel: link attempts first, then application tries
              if (link_try_q < LINK_ATTEMPTS - 2'h1) begin
                link_try_q <= link_try_q + 2'h1;
                state_q <= S_SEND;
              end else if (app_left && !bcast_q) begin
                app_try_q <= app_try_q + 8'h01;
                link_try_q <= 2'h0;
                state_q <= S_SEND;
              end else begin
                code_q <= ST_CCA_FAIL;
                state_q <= S_DONE;
              end
            end else if (bcast_q) begin
              code_q <= ST_SUCCESS;
              state_q <= S_DONE;
            end else if (ack_on && !ack_sync_q[1]) begin
              // No link acknowledgment: resend up to the link limit
              if (link_try_q < LINK_RETRIES_MAX) begin
                link_try_q <= link_try_q + 2'h1;
                state_q <= S_SEND;
              end else if (app_left) begin
                app_try_q <= app_try_q + 8'h01;
                link_try_q <= 2'h0;
                state_q <= S_SEND;
              end else begin
                code_q <= app_on ? ST_NET_ACK_FAIL : ST_NO_ACK;
                state_q <= S_DONE;
              end
            end else if (app_on && !nack_sync_q[1]) begin
              // Link ok but no application-level acknowledgment
              if (app_left) begin
                app_try_q <= app_try_q + 8'h01;
                link_try_q <= 2'h0;
                state_q <= S_SEND;
              end else begin
                code_q <= ST_NET_ACK_FAIL;
                state_q <= S_DONE;
              end
            end else begin
              code_q <= ST_SUCCESS;
              state_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Radio request outputs, launched once per attempt
  // Flags stay latched between launches so the far side never sees them move
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      radio_start <= 1'b0;
      radio_hdr_en <= 1'b0;
      radio_dup_detect <= 1'b0;
      radio_ack_req <= 1'b0;
      radio_broadcast <= 1'b0;
    end else begin
      radio_start <= (state_q == S_SEND);
      if (state_q == S_SEND) begin
        radio_hdr_en <= hdr_on;
        radio_dup_detect <= hdr_on;
        radio_ack_req <= ack_on & ~bcast_q;
        radio_broadcast <= bcast_q;
      end
    end
  end

  // ==========================================================
  // Transmit status record
  assign status_evt = (state_q == S_DONE) & (frame_id_q != 8'h00);
  // A request that finds the engine busy is lost; only its flag remains
  assign drop_evt = req_wr & (state_q != S_IDLE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_id_q <= 8'h00;
      last_code_q <= ST_SUCCESS;
      last_link_q <= 2'h0;
      last_app_q <= 8'h00;
    end else if (status_evt) begin
      last_id_q <= frame_id_q;
      last_code_q <= code_q;
      last_link_q <= link_try_q;
      last_app_q <= app_try_q;
    end
  end

  // ==========================================================
  // Event vector in status-bit order
  always_comb begin
    irq_set = 2'h0;
    irq_set[IRQ_STATUS_BIT] = status_evt;
    irq_set[IRQ_DROP_BIT] = drop_evt;
  end

  // Interrupt status: set wins over read clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= ((bus_rd && wb_adr_i == ADDR_IRQ_STAT) ? 2'h0 : irq_stat_q)
                    | irq_set;
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Read mux
  // Unmapped offsets read as zero and are still acked
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_CTRL: begin
        rd_d[CTRL_MODE_LSB +: 2] = mac_mode_setting_q;
        rd_d[CTRL_RR_LSB +: 8] = application_retry_count_q;
      end
      ADDR_TXREQ: begin
        rd_d[TXREQ_ID_LSB +: 8] = frame_id_q;
        rd_d[TXREQ_BCAST_BIT] = bcast_q;
      end
      ADDR_TXSTAT: begin
        rd_d[7:0] = last_id_q;
        rd_d[TXSTAT_CODE_LSB +: 8] = last_code_q;
        rd_d[TXSTAT_LINK_LSB +: 2] = last_link_q;
        rd_d[TXSTAT_APP_LSB +: 7] = last_app_q[6:0];
        rd_d[TXSTAT_BUSY_BIT] = (state_q != S_IDLE);
      end
      ADDR_IRQ_STAT: rd_d[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rd_d[IRQ_W-1:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus answer: ack one cycle after the request is seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? rd_d : 32'h0000_0000;
    end
  end

endmodule : tx_retry_ctrl

`default_nettype wire

/* File: verif/radio_node.sv */
// Purpose: Remote radio node for the bench
// Assumes: Result pins settle before each toggle
// Notes: Pins turn stale at every launch
`timescale 1ns/1ps
`default_nettype none
module radio_node (
  // Clock, reset, scenario
  input wire logic clk,
  input wire logic arst_n,
  input wire logic busy,
  input wire logic reach,
  input wire logic [3:0] lat,
  // Radio pins
  input wire logic radio_start,
  input wire logic radio_ack_req,
  output logic radio_done_tgl,
  output logic radio_cca_fail,
  output logic radio_ack_rcvd,
  output logic radio_net_ack
);
  logic [4:0] cnt_q;
  // Air time, then result, then toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
      {radio_done_tgl, radio_cca_fail, radio_ack_rcvd, radio_net_ack} <= 4'h0;
    end else if (radio_start) begin
      cnt_q <= {1'b0, lat} + 5'h02;
      {radio_cca_fail, radio_ack_rcvd, radio_net_ack} <= ~{radio_cca_fail, radio_ack_rcvd, radio_net_ack};
    end else if (cnt_q == 5'h02) begin
      cnt_q <= 5'h01;
      radio_cca_fail <= busy;
      radio_ack_rcvd <= radio_ack_req && reach && !busy;
      radio_net_ack <= reach && !busy;
    end else if (cnt_q == 5'h01) begin
      cnt_q <= 5'h00;
      radio_done_tgl <= ~radio_done_tgl;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule : radio_node
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for tx_retry_ctrl
// Assumes: Radio node model on the far side
// Notes: Xorshift from a fixed seed picks cases
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tx_retry_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic busy = 1'b0;
  logic reach = 1'b1;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd, q, rnd;
  logic ack, start, areq, tgl, ccaf, ackr, neta, irq;
  int failures = 0;
  int cmp_count = 0;
  int starts = 0;
  int ticks = 0;
  always #10 clk = ~clk;
  tx_retry_ctrl u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .radio_start(start),
    .radio_hdr_en(), .radio_dup_detect(), .radio_ack_req(areq), .radio_broadcast(), .radio_done_tgl(tgl),
    .radio_cca_fail(ccaf), .radio_ack_rcvd(ackr), .radio_net_ack(neta), .irq(irq));
  radio_node u_node (.clk(clk), .arst_n(arst_n), .busy(busy), .reach(reach), .lat(lat),
    .radio_start(start), .radio_ack_req(areq), .radio_done_tgl(tgl), .radio_cca_fail(ccaf),
    .radio_ack_rcvd(ackr), .radio_net_ack(neta));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Launches, app retries, code, link retries
  function automatic logic [31:0] want(input int m, r, oc, b);
    int a, ap, apps, per, lnk;
    logic [7:0] code;
    a = (m == 0 || m == 2) && !b;
    ap = (m == 0 || m == 3) && r != 0 && !b;
    apps = (ap && oc != 0) ? r : 0;
    per = (oc == 2) ? 3 : (a && oc == 1) ? 4 : 1;
    code = (oc == 2) ? ST_CCA_FAIL : (oc == 0 || b) ? ST_SUCCESS : ap ? ST_NET_ACK_FAIL : a ? ST_NO_ACK : ST_SUCCESS;
    // A busy channel ends each try after three attempts, that is two link retries
    lnk = (oc == 2) ? int'(LINK_ATTEMPTS) - 1 : (a && oc == 1) ? 3 : 0;
    return {8'(per * (apps + 1)), 8'(apps), code, 8'(lnk)};
  endfunction : want
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rd;
    cyc <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic run(input int m, r, oc, b);
    logic [31:0] w;
    int s0;
    rnd = xs(rnd);
    w = want(m, r, oc, b);
    wb(1'b1, ADDR_CTRL, {16'h0, 8'(r), 6'h0, 2'(m)});
    busy <= (oc == 2);
    reach <= (oc == 0);
    lat <= rnd[11:8];
    s0 = starts;
    wb(1'b1, ADDR_TXREQ, {23'h0, 1'(b), rnd[7:1], 1'b1});
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, ADDR_TXSTAT, 32'h0);
    chk(32'(q[15:0]), {16'h0, w[15:8], rnd[7:1], 1'b1});
    chk(32'(q[30:24]), 32'(w[23:16]));
    chk(32'(q[17:16]), 32'(w[7:0]));
    chk(starts - s0, 32'(w[31:24]));
    chk(32'(irq), 32'h0);
    $display("test mode=%0d rr=%0d case=%0d bcast=%0d done", m, r, oc, b);
  endtask : run
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Launch count and hang guard
  always @(posedge clk) begin
    ticks++;
    if (start === 1'b1) begin
      starts++;
    end
    if (ticks == 60000) begin
      failures++;
      results();
    end
  end
  // ==========
  // Main sequence
  initial begin
    rnd = 32'h0000005D;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    $display("test reset values done");
    wb(1'b1, ADDR_IRQ_MASK, 32'h3);
    // Every mode and outcome, with and without app retries, plus broadcast
    for (int m = 0; m < 4; m++) begin
      for (int oc = 0; oc < 3; oc++) begin
        run(m, 0, oc, 0);
        run(m, 2, oc, 0);
        run(m, 1, oc, 1);
      end
    end
    repeat (20) run(rnd[1:0], rnd[9:8], rnd[5:4] % 3, rnd[12] & rnd[13]);
    // Frame id zero gets no status
    busy <= 1'b0;
    reach <= 1'b1;
    wb(1'b1, ADDR_TXREQ, 32'h0);
    repeat (400) @(posedge clk);
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    $display("test zero id done");
    // Request while busy is dropped, its flag masked
    wb(1'b1, ADDR_IRQ_MASK, 32'h1);
    wb(1'b1, ADDR_TXREQ, 32'h5);
    wb(1'b1, ADDR_TXREQ, 32'h6);
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h3);
    wb(1'b0, ADDR_TXSTAT, 32'h0);
    chk(32'(q[7:0]), 32'h5);
    $display("test dropped request done");
    results();
  end
endmodule : tb
`default_nettype wire

/* File: verif/tx_retry_checker.sv */
// Purpose: Port checks for tx_retry_ctrl
// Assumes: Mode mirrored from bus writes
// Notes: Bound below the module
`timescale 1ns/1ps
`default_nettype none
module tx_retry_checker
  import tx_retry_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Radio launch
  input wire logic radio_start,
  input wire logic radio_hdr_en,
  input wire logic radio_dup_detect,
  input wire logic radio_ack_req,
  input wire logic radio_broadcast
);
  logic take;
  logic [1:0] mode_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Mirror of the mode field
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL) begin
      mode_q <= wb_dat_i[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Checks
  AST_BUS_ACK: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one pulse");
  AST_BUS_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_START_PULSE: assert property (radio_start |=> !radio_start [*2])
    else $error("launch pulse too long");
  AST_HDR: assert property (
    radio_start |-> radio_hdr_en == (mode_q == 2'h0 || mode_q == 2'h3))
    else $error("header flag wrong for mode");
  AST_DUP: assert property (radio_start |-> radio_dup_detect == radio_hdr_en)
    else $error("duplicate detect differs");
  AST_ACK_REQ: assert property (
    radio_start && !radio_broadcast |-> radio_ack_req == !mode_q[0])
    else $error("ack request wrong for mode");
  AST_BCAST: assert property (radio_start && radio_broadcast |-> !radio_ack_req)
    else $error("broadcast asks for ack");
  AST_FLAGS_HOLD: assert property (
    !radio_start |-> $stable({radio_hdr_en, radio_ack_req, radio_broadcast}))
    else $error("flags moved between launches");
  cover property (radio_start && radio_broadcast);
  cover property (radio_start && radio_ack_req);
  cover property (take && wb_we_i && wb_adr_i == ADDR_TXREQ);
endmodule : tx_retry_checker
bind tx_retry_ctrl tx_retry_checker u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .radio_start, .radio_hdr_en, .radio_dup_detect,
  .radio_ack_req, .radio_broadcast);
`default_nettype wire
